/* sync_control_command_generator.sv */
// orbit-synchronised control command generators with an AHB-Lite register slave
// How it works
// RULE1 - every control command byte leaves with bit 7 clear
// RULE2 - reset commands set bit 6; all other commands keep it clear
// RULE3 - bunch clear goes out every orbit once an orbit source exists
// RULE4 - bunch clear is bit 0, joined only by event clear
// RULE5 - bunch clear wins every slot and its slot is kept free
// RULE6 - bunch clear follows a programmable offset and cannot be disabled
// RULE7 - internal bunch clear lags the orbit by its own programmable delay
// RULE8 - event clear runs periodically when enabled, or once on demand
// RULE9 - event clear is bit 1 and always rides with a bunch clear
// RULE10 - internal event id clear pulses together with internal bunch clear
// RULE11 - front-end reset throttles, drains, sends, then releases after recovery
// RULE12 - front-end reset is reset class with bit 2, mergeable with others
// RULE13 - front-end reset has period, start, drain delay 576 and release delay
// RULE14 - front-end reset runs periodically when enabled, or on demand
// RULE15 - a lost command slot sets a repeat flag and retries next orbit
// RULE16 - front-end generator stays reset while the combined sequence runs
// RULE17 - combined reset throttles both levels, stops, flushes, sends, then releases
// RULE18 - combined reset carries bits 3 and 2 as reset class
// RULE19 - combined reset has period, start, flush delay and release delay
// RULE20 - combined reset runs periodically when enabled, or on demand
// RULE21 - user command sends its code at a crossing, periodic or demanded
// RULE22 - generators are orbit timed, separately enabled, reset and counted
// RULE23 - demand bits clear themselves once their command is handed over
//
// Implementation choices: the AHB-Lite register port and the register addresses.
`default_nettype none
module sync_control_command_generator (
	input  wire logic                       core_clk,
	input  wire logic                       sys_rst,
	input  wire logic                       hsel,
	input  wire logic [31:0]                haddr,
	input  wire logic [1:0]                 htrans,
	input  wire logic                       hwrite,
	input  wire logic [2:0]                 hsize,
	input  wire logic [31:0]                hwdata,
	input  wire logic                       hready,
	output logic      [31:0]                hrdata,
	output logic                            hreadyout,
	output logic                            hresp,
	input  wire logic                       orbit_ext,
	input  wire logic                       slot_busy,
	input  wire logic                       fe_ready,
	input  wire logic                       l1_empty,
	output cmd_gen_pkg::bcast_cmd_type      cmd_out,
	output logic                            bunch_clear_int,
	output logic                            event_id_clear_int,
	output logic                            l0_throttle,
	output logic                            l1_throttle,
	output logic                            l1_tx_stop,
	output logic                            flush_req
);
	import cmd_gen_pkg::*;

	// ****************************************
	// register state
	// ****************************************
	logic [4:0]       ctrl_r;
	logic [3:0]       req_r;
	logic [4:0]       grst_r;
	logic [CFG_W-1:0] cfg_r [NUM_CFG];
	logic [CNT_W-1:0] cnt_r [NUM_CNT];
	logic             wr_ph_r;
	logic [7:0]       addr_ph_r;
	logic             addr_take;
	logic [31:0]      rd_val;

	// ****************************************
	// timing state
	// ****************************************
	logic [BX_W-1:0]  bx_r;
	logic             orbit_ok;
	logic             orbit_hit;
	logic [CFG_W-1:0] dly_cnt_r;
	logic             dly_run_r;
	logic [CFG_W-1:0] ec_per_r;
	logic             ec_pend_r;
	logic             bc_slot;
	logic             ec_sent;

	// ****************************************
	// generator handshake
	// ****************************************
	logic want_fe, want_cb, want_us;
	logic grant_fe, grant_cb, grant_us;
	logic thr_fe, thr_cb, start_cb;
	logic done_fe, done_cb, done_us;
	logic rpt_fe, rpt_cb, rpt_us;
	logic act_fe, act_cb;
	logic fe_hold;
	logic send;
	logic [7:0] code;

	assign addr_take = hsel && hready && htrans == HTRANS_NONSEQ;

	// ****************************************
	// orbit and crossing counter
	// ****************************************
	// orbit exists once external is selected or a length is programmed
	assign orbit_ok  = ctrl_r[CTRL_EXT_ORBIT] || cfg_r[CFG_ORBIT_LEN] != '0; // RULE3
	assign orbit_hit = ctrl_r[CTRL_EXT_ORBIT] ? orbit_ext :
		(orbit_ok && bx_r == BX_W'(cfg_r[CFG_ORBIT_LEN] - 1'b1)); // RULE22

	// crossing count since the last orbit pulse
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			bx_r <= '0;
		end else if (orbit_hit) begin
			bx_r <= '0;
		end else begin
			bx_r <= bx_r + 1'b1;
		end
	end

	// ****************************************
	// bunch clear and event clear
	// ****************************************
	// no enable gates this: the slot is taken whenever an orbit exists
	assign bc_slot = orbit_ok && bx_r == cfg_r[CFG_BC_TX_OFS][BX_W-1:0]; // RULE6
	assign ec_sent = bc_slot && ec_pend_r;

	// internal clear delayed from the orbit; event id clear shares the pulse
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dly_cnt_r          <= '0;
			dly_run_r          <= 1'b0;
			bunch_clear_int    <= 1'b0;
			event_id_clear_int <= 1'b0;
		end else begin
			bunch_clear_int    <= 1'b0;
			event_id_clear_int <= 1'b0;
			if (orbit_hit) begin
				dly_cnt_r <= '0;
				dly_run_r <= 1'b1;
			end else if (dly_run_r) begin
				if (dly_cnt_r >= cfg_r[CFG_BC_INT_DLY]) begin // RULE7
					dly_run_r          <= 1'b0;
					bunch_clear_int    <= 1'b1;
					event_id_clear_int <= 1'b1; // RULE10
				end else begin
					dly_cnt_r <= dly_cnt_r + 1'b1;
				end
			end
		end
	end

	// event clear period counter and pending flag; a new cause beats the clear
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ec_per_r  <= '0;
			ec_pend_r <= 1'b0;
		end else if (grst_r[GEN_EC]) begin
			ec_per_r  <= '0;
			ec_pend_r <= 1'b0;
		end else begin
			if (orbit_hit && ctrl_r[CTRL_EC_EN]) begin
				ec_per_r <= (ec_per_r >= cfg_r[CFG_EC_PERIOD]) ? '0 : ec_per_r + 1'b1;
			end
			if ((orbit_hit && ctrl_r[CTRL_EC_EN] && ec_per_r >= cfg_r[CFG_EC_PERIOD]) ||
				(req_r[GEN_EC] && !ec_sent)) begin
				ec_pend_r <= 1'b1; // RULE8
			end else if (ec_sent) begin
				ec_pend_r <= 1'b0;
			end
		end
	end

	// ****************************************
	// sequence generators
	// ****************************************
	// the combined sequence holds the front-end generator in reset
	assign fe_hold = grst_r[GEN_FE] || act_cb; // RULE16

	orbit_sequence_gen u_fe_seq (
		.core_clk    (core_clk),
		.sys_rst     (sys_rst),
		.gen_rst     (fe_hold),
		.enable      (ctrl_r[CTRL_FE_EN]),
		.demand      (req_r[GEN_FE]),
		.orbit_hit   (orbit_hit),
		.bx          (bx_r),
		.start_bx    (cfg_r[CFG_FE_START]),
		.period      (cfg_r[CFG_FE_PERIOD]),
		.drain_dly   (cfg_r[CFG_FE_DRAIN]),
		.release_dly (cfg_r[CFG_FE_RELEASE]),
		.ready_ok    (fe_ready),
		.grant       (grant_fe),
		.want        (want_fe),
		.throttle    (thr_fe),
		.started     (),
		.done        (done_fe),
		.repeat_flag (rpt_fe),
		.active      (act_fe)
	); // RULE11 RULE13 RULE14

	orbit_sequence_gen u_cb_seq (
		.core_clk    (core_clk),
		.sys_rst     (sys_rst),
		.gen_rst     (grst_r[GEN_CB]),
		.enable      (ctrl_r[CTRL_CB_EN]),
		.demand      (req_r[GEN_CB]),
		.orbit_hit   (orbit_hit),
		.bx          (bx_r),
		.start_bx    (cfg_r[CFG_CB_START]),
		.period      (cfg_r[CFG_CB_PERIOD]),
		.drain_dly   (cfg_r[CFG_CB_FLUSH]),
		.release_dly (cfg_r[CFG_CB_RELEASE]),
		.ready_ok    (fe_ready && l1_empty),
		.grant       (grant_cb),
		.want        (want_cb),
		.throttle    (thr_cb),
		.started     (start_cb),
		.done        (done_cb),
		.repeat_flag (rpt_cb),
		.active      (act_cb)
	); // RULE17 RULE19 RULE20

	// user command: zero drain and release delays, just the crossing slot
	orbit_sequence_gen u_usr_seq (
		.core_clk    (core_clk),
		.sys_rst     (sys_rst),
		.gen_rst     (grst_r[GEN_USR]),
		.enable      (ctrl_r[CTRL_USR_EN]),
		.demand      (req_r[GEN_USR]),
		.orbit_hit   (orbit_hit),
		.bx          (bx_r),
		.start_bx    (cfg_r[CFG_USR_CROSS]),
		.period      (cfg_r[CFG_USR_PERIOD]),
		.drain_dly   (CFG_RST),
		.release_dly (CFG_RST),
		.ready_ok    (1'b1),
		.grant       (grant_us),
		.want        (want_us),
		.throttle    (),
		.started     (),
		.done        (done_us),
		.repeat_flag (rpt_us),
		.active      ()
	); // RULE21

	// ****************************************
	// command selection
	// ****************************************
	// bunch clear takes its slot unconditionally; resets merge into one byte;
	// whatever loses the slot falls back to its repeat path
	always_comb begin
		send     = 1'b0;
		code     = '0;
		grant_fe = 1'b0;
		grant_cb = 1'b0;
		grant_us = 1'b0;
		if (bc_slot) begin
			send = 1'b1; // RULE5
			code = BIT_BUNCH | (ec_pend_r ? BIT_EVENT : 8'h00); // RULE4 RULE9
		end else if (!slot_busy && (want_fe || want_cb)) begin
			send     = 1'b1;
			grant_fe = want_fe;
			grant_cb = want_cb;
			code     = RESET_CLASS | (want_fe ? BIT_FE : 8'h00) | // RULE2 RULE12
				(want_cb ? (BIT_COMB | BIT_FE) : 8'h00); // RULE18
		end else if (!slot_busy && want_us) begin
			send     = 1'b1;
			grant_us = 1'b1;
			code     = cfg_r[CFG_USR_CODE][7:0] & PLAIN_MASK; // RULE2
		end
	end

	// command handed to the arbiter as a one-cycle strobe
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cmd_out <= '0;
		end else begin
			cmd_out.valid <= send;
			cmd_out.code  <= {1'b0, code[6:0]}; // RULE1
		end
	end

	// ****************************************
	// trigger control outputs
	// ****************************************
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			l0_throttle <= 1'b0;
			l1_throttle <= 1'b0;
			l1_tx_stop  <= 1'b0;
			flush_req   <= 1'b0;
		end else begin
			l0_throttle <= thr_fe || thr_cb; // RULE11
			l1_throttle <= thr_cb; // RULE17
			l1_tx_stop  <= thr_cb;
			flush_req   <= start_cb;
		end
	end

	// ****************************************
	// command counters
	// ****************************************
	// one counter per command; a generator reset clears its own counter
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < NUM_CNT; i++) begin
				cnt_r[i] <= '0;
			end
		end else begin
			cnt_r[CNT_BC]  <= grst_r[GEN_BC] ? '0 : cnt_r[CNT_BC] + CNT_W'(bc_slot); // RULE22
			cnt_r[CNT_EC]  <= grst_r[GEN_EC] ? '0 : cnt_r[CNT_EC] + CNT_W'(ec_sent);
			cnt_r[CNT_FE]  <= grst_r[GEN_FE] ? '0 : cnt_r[CNT_FE] + CNT_W'(grant_fe);
			cnt_r[CNT_CB]  <= grst_r[GEN_CB] ? '0 : cnt_r[CNT_CB] + CNT_W'(grant_cb);
			cnt_r[CNT_USR] <= grst_r[GEN_USR] ? '0 : cnt_r[CNT_USR] + CNT_W'(grant_us);
		end
	end

	// ****************************************
	// AHB-Lite slave
	// ****************************************
	// read data is prepared from the address phase, so no wait states occur
	always_comb begin
		rd_val = '0;
		unique case (1'b1)
			haddr[7:0] == CTRL_OFS: rd_val = {27'h0, ctrl_r};
			haddr[7:0] == REQ_OFS:  rd_val = {28'h0, req_r};
			haddr[7:0] == STAT_OFS: rd_val = {25'h0, act_cb, act_fe, thr_cb, thr_fe,
				rpt_us, rpt_cb, rpt_fe}; // RULE15
			haddr[7:6] == CFG_BASE[7:6]: rd_val = {16'h0, cfg_r[haddr[5:2]]};
			haddr[7:5] == CNT_BASE[7:5] && haddr[4:2] < 3'(NUM_CNT):
				rd_val = cnt_r[haddr[4:2]];
			default: rd_val = '0;
		endcase
		if (haddr[31:8] != '0) begin
			rd_val = '0;
		end
	end

	// address phase capture and read data
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ph_r   <= 1'b0;
			addr_ph_r <= '0;
			hrdata    <= '0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_ph_r   <= addr_take && hwrite && haddr[31:8] == '0;
			if (addr_take) begin
				addr_ph_r <= haddr[7:0];
				hrdata    <= hwrite ? 32'h0 : rd_val;
			end
		end
	end

	// control bits and configuration words written in the data phase
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_r <= '0;
			for (int i = 0; i < NUM_CFG; i++) begin
				cfg_r[i] <= cfg_reset(i);
			end
		end else if (wr_ph_r) begin
			if (addr_ph_r == CTRL_OFS) begin
				ctrl_r <= hwdata[4:0];
			end
			if (addr_ph_r[7:6] == CFG_BASE[7:6]) begin
				cfg_r[addr_ph_r[5:2]] <= hwdata[CFG_W-1:0];
			end
		end
	end

	// generator resets are one-cycle pulses from a write of ones
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			grst_r <= '0;
		end else begin
			grst_r <= (wr_ph_r && addr_ph_r == GRST_OFS) ? hwdata[4:0] : 5'h00; // RULE22
		end
	end

	// demand bits: written ones set, hand-over clears, a new set wins
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			req_r <= '0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (wr_ph_r && addr_ph_r == REQ_OFS && hwdata[i]) begin
					req_r[i] <= 1'b1;
				end else if (grst_r[i]) begin
					req_r[i] <= 1'b0;
				end
			end
			if (ec_sent && !(wr_ph_r && addr_ph_r == REQ_OFS && hwdata[GEN_EC])) begin
				req_r[GEN_EC] <= 1'b0; // RULE23
			end
			if (done_fe && !(wr_ph_r && addr_ph_r == REQ_OFS && hwdata[GEN_FE])) begin
				req_r[GEN_FE] <= 1'b0; // RULE23
			end
			if (done_cb && !(wr_ph_r && addr_ph_r == REQ_OFS && hwdata[GEN_CB])) begin
				req_r[GEN_CB] <= 1'b0; // RULE23
			end
			if (done_us && !(wr_ph_r && addr_ph_r == REQ_OFS && hwdata[GEN_USR])) begin
				req_r[GEN_USR] <= 1'b0; // RULE23
			end
		end
	end
endmodule // sync_control_command_generator
`default_nettype wire

/* cmd_gen_pkg.sv */
// shared constants and types of the synchronous control command generator
`default_nettype none
package cmd_gen_pkg;
	// ****************************************
	// widths
	// ****************************************
	localparam int BX_W  = 12;
	localparam int CFG_W = 16;
	localparam int CNT_W = 32;
	localparam int NUM_CFG = 16;
	localparam int NUM_CNT = 5;

	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] REQ_OFS  = 8'h04;
	localparam logic [7:0] GRST_OFS = 8'h08;
	localparam logic [7:0] STAT_OFS = 8'h0C;
	localparam logic [7:0] CFG_BASE = 8'h40;
	localparam logic [7:0] CNT_BASE = 8'h80;

	// ****************************************
	// configuration word indices
	// ****************************************
	localparam int CFG_ORBIT_LEN  = 0;
	localparam int CFG_BC_TX_OFS  = 1;
	localparam int CFG_BC_INT_DLY = 2;
	localparam int CFG_EC_PERIOD  = 3;
	localparam int CFG_FE_PERIOD  = 4;
	localparam int CFG_FE_START   = 5;
	localparam int CFG_FE_DRAIN   = 6;
	localparam int CFG_FE_RELEASE = 7;
	localparam int CFG_CB_PERIOD  = 8;
	localparam int CFG_CB_START   = 9;
	localparam int CFG_CB_FLUSH   = 10;
	localparam int CFG_CB_RELEASE = 11;
	localparam int CFG_USR_CODE   = 12;
	localparam int CFG_USR_CROSS  = 13;
	localparam int CFG_USR_PERIOD = 14;
	localparam logic [CFG_W-1:0] FE_DRAIN_RST = 16'h0240;
	localparam logic [CFG_W-1:0] CFG_RST      = 16'h0000;

	// ****************************************
	// bit positions of control, request, generator reset
	// ****************************************
	localparam int CTRL_EXT_ORBIT = 0;
	localparam int CTRL_EC_EN     = 1;
	localparam int CTRL_FE_EN     = 2;
	localparam int CTRL_CB_EN     = 3;
	localparam int CTRL_USR_EN    = 4;
	localparam int GEN_EC  = 0;
	localparam int GEN_FE  = 1;
	localparam int GEN_CB  = 2;
	localparam int GEN_USR = 3;
	localparam int GEN_BC  = 4;

	// ****************************************
	// counter indices
	// ****************************************
	localparam int CNT_BC  = 0;
	localparam int CNT_EC  = 1;
	localparam int CNT_FE  = 2;
	localparam int CNT_CB  = 3;
	localparam int CNT_USR = 4;

	// ****************************************
	// short broadcast encoding
	// ****************************************
	localparam logic [7:0] BIT_BUNCH   = 8'h01;
	localparam logic [7:0] BIT_EVENT   = 8'h02;
	localparam logic [7:0] BIT_FE      = 8'h04;
	localparam logic [7:0] BIT_COMB    = 8'h08;
	localparam logic [7:0] RESET_CLASS = 8'h40;
	localparam logic [7:0] PLAIN_MASK  = 8'h3F;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef struct packed {
		logic       valid;
		logic [7:0] code;
	} bcast_cmd_type;

	typedef enum {SEQ_IDLE, SEQ_WAIT_BX, SEQ_DRAIN, SEQ_SEND, SEQ_RELEASE} seq_state_type;

	// value each configuration word takes after reset
	function automatic logic [CFG_W-1:0] cfg_reset(input int idx);
		cfg_reset = (idx == CFG_FE_DRAIN) ? FE_DRAIN_RST : CFG_RST;
	endfunction
endpackage
`default_nettype wire

/* orbit_sequence_gen.sv */
// orbit-timed sequence generator: throttle, command slot, release
`default_nettype none
module orbit_sequence_gen (
	input  wire logic                         core_clk,
	input  wire logic                         sys_rst,
	input  wire logic                         gen_rst,
	input  wire logic                         enable,
	input  wire logic                         demand,
	input  wire logic                         orbit_hit,
	input  wire logic [cmd_gen_pkg::BX_W-1:0]  bx,
	input  wire logic [cmd_gen_pkg::CFG_W-1:0] start_bx,
	input  wire logic [cmd_gen_pkg::CFG_W-1:0] period,
	input  wire logic [cmd_gen_pkg::CFG_W-1:0] drain_dly,
	input  wire logic [cmd_gen_pkg::CFG_W-1:0] release_dly,
	input  wire logic                         ready_ok,
	input  wire logic                         grant,
	output logic                              want,
	output logic                              throttle,
	output logic                              started,
	output logic                              done,
	output logic                              repeat_flag,
	output logic                              active
);
	import cmd_gen_pkg::*;

	seq_state_type    state_r;
	logic [CFG_W-1:0] per_r;
	logic [CFG_W-1:0] cnt_r;
	logic             armed_r;
	logic             at_start;

	assign at_start = (bx == start_bx[BX_W-1:0]);
	assign want     = (state_r == SEQ_SEND);
	assign active   = (state_r != SEQ_IDLE);
	// throttle while draining, in the slot, while releasing, and over a retry wait
	assign throttle = (state_r == SEQ_DRAIN) || (state_r == SEQ_SEND) ||
		(state_r == SEQ_RELEASE) || (state_r == SEQ_WAIT_BX && repeat_flag);

	// orbit period counter; arms a periodic run only while enabled
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			per_r   <= '0;
			armed_r <= 1'b0;
		end else if (gen_rst) begin
			per_r   <= '0;
			armed_r <= 1'b0;
		end else if (state_r == SEQ_IDLE && (armed_r || demand)) begin
			armed_r <= 1'b0;
		end else if (orbit_hit && enable) begin
			if (per_r >= period) begin
				per_r   <= '0;
				armed_r <= 1'b1;
			end else begin
				per_r <= per_r + 1'b1;
			end
		end
	end

	// sequence: start crossing, drain delay, command slot, release delay
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r     <= SEQ_IDLE;
			cnt_r       <= '0;
			repeat_flag <= 1'b0;
			started     <= 1'b0;
			done        <= 1'b0;
		end else if (gen_rst) begin
			state_r     <= SEQ_IDLE;
			cnt_r       <= '0;
			repeat_flag <= 1'b0;
			started     <= 1'b0;
			done        <= 1'b0;
		end else begin
			started <= 1'b0;
			done    <= 1'b0;
			unique case (state_r)
				SEQ_IDLE: begin
					if (armed_r || demand) begin
						state_r <= SEQ_WAIT_BX;
					end
				end
				SEQ_WAIT_BX: begin
					if (at_start) begin
						state_r <= SEQ_DRAIN;
						cnt_r   <= '0;
						started <= !repeat_flag;
					end
				end
				SEQ_DRAIN: begin
					if (cnt_r >= drain_dly) begin
						state_r <= SEQ_SEND;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				SEQ_SEND: begin
					cnt_r <= '0;
					if (grant) begin
						state_r     <= SEQ_RELEASE;
						repeat_flag <= 1'b0;
						done        <= 1'b1;
					end else begin
						// lost the slot: retry at the same crossing next orbit
						state_r     <= SEQ_WAIT_BX; // RULE15
						repeat_flag <= 1'b1; // RULE15
					end
				end
				SEQ_RELEASE: begin
					if (cnt_r < release_dly) begin
						cnt_r <= cnt_r + 1'b1;
					end else if (ready_ok) begin
						state_r <= SEQ_IDLE;
					end
				end
			endcase
		end
	end
endmodule // orbit_sequence_gen
`default_nettype wire

/* cmd_gen_checker.sv */
// assertions on the command and throttle ports
`default_nettype none
module cmd_gen_checker (
	input wire logic			core_clk,
	input wire logic			sys_rst,
	input wire cmd_gen_pkg::bcast_cmd_type	cmd_out,
	input wire logic			bunch_clear_int,
	input wire logic			event_id_clear_int,
	input wire logic			l0_throttle,
	input wire logic			l1_throttle,
	input wire logic			l1_tx_stop,
	input wire logic			flush_req,
	input wire logic			fe_ready,
	input wire logic			l1_empty
);
	import cmd_gen_pkg::*;
	// ****
	// output relations
	// ****
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	property p_b7; cmd_out.valid |-> !cmd_out.code[7]; endproperty
	a_b7: assert property (p_b7) else $error("bit 7 set");
	property p_fe; cmd_out.valid && cmd_out.code[2] |-> cmd_out.code[6] && l0_throttle; endproperty
	a_fe: assert property (p_fe) else $error("bad front-end reset");
	property p_ec; cmd_out.valid && cmd_out.code[1] |-> cmd_out.code == 8'h03; endproperty
	a_ec: assert property (p_ec) else $error("event clear alone");
	property p_bc; cmd_out.valid && cmd_out.code[0] |-> cmd_out.code[7:2] == 6'h00; endproperty
	a_bc: assert property (p_bc) else $error("bunch clear mixed");
	property p_cb; cmd_out.valid && cmd_out.code[3] |-> cmd_out.code[2] && l1_throttle; endproperty
	a_cb: assert property (p_cb) else $error("bad combined reset");
	property p_eid; event_id_clear_int |-> bunch_clear_int; endproperty
	a_eid: assert property (p_eid) else $error("id clear off time");
	property p_stop; l1_throttle |-> l1_tx_stop && l0_throttle; endproperty
	a_stop: assert property (p_stop) else $error("partial throttle");
	property p_fl; flush_req |-> ##[0:2] l1_throttle; endproperty
	a_fl: assert property (p_fl) else $error("flush unthrottled");
	property p_rel; $fell(l1_throttle) |-> $past(l1_empty) && $past(fe_ready); endproperty
	a_rel: assert property (p_rel) else $error("early release");
	property p_rl0; $fell(l0_throttle) |-> $past(fe_ready); endproperty
	a_rl0: assert property (p_rl0) else $error("early fe release");
endmodule // cmd_gen_checker
`default_nettype wire

/* bcast_partner.sv */
// behavioural broadcast arbiter and front-end recovery model
`default_nettype none
module bcast_partner (
	input wire logic			core_clk,
	input wire logic			sys_rst,
	input wire logic			busy,
	input wire cmd_gen_pkg::bcast_cmd_type	cmd_out,
	input wire logic			flush_req,
	output logic				slot_busy,
	output logic				fe_ready,
	output logic				l1_empty
);
	import cmd_gen_pkg::*;
	logic [5:0]	fe_cnt_r;
	logic [5:0]	l1_cnt_r;
	// ****
	// recovery timers
	// ****
	// front-end is unready for a while after a reset byte, so release has to wait
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) fe_cnt_r <= 6'h00;
		else if (cmd_out.valid && cmd_out.code[2]) fe_cnt_r <= 6'h14;
		else if (fe_cnt_r != 6'h00) fe_cnt_r <= fe_cnt_r - 6'h01;
	end
	// second level drains for a while after each flush
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) l1_cnt_r <= 6'h00;
		else if (flush_req) l1_cnt_r <= 6'h1E;
		else if (l1_cnt_r != 6'h00) l1_cnt_r <= l1_cnt_r - 6'h01;
	end
	// slots are claimed only on the bench's word; bunch clear needs no grant
	assign slot_busy = busy;
	assign fe_ready  = (fe_cnt_r == 6'h00);
	assign l1_empty  = (l1_cnt_r == 6'h00);
endmodule // bcast_partner
`default_nettype wire

/* tb.sv */
// self-checking bench for the command generator
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import cmd_gen_pkg::*;
	logic		core_clk = 1'b0;
	logic		sys_rst = 1'b1;
	logic		hsel = 1'b0;
	logic [31:0]	haddr = 32'h0;
	logic [1:0]	htrans = 2'h0;
	logic		hwrite = 1'b0;
	logic [2:0]	hsize = 3'h2;
	logic [31:0]	hwdata = 32'h0;
	logic		orbit_ext = 1'b0;
	logic		busy = 1'b0;
	logic [31:0]	hrdata, q;
	logic		hreadyout, hresp, slot_busy, fe_ready, l1_empty, flush_req;
	logic		bunch_clear_int, event_id_clear_int, l0_throttle, l1_throttle, l1_tx_stop;
	bcast_cmd_type	cmd_out;
	int		n_fail = 0;
	int		tests_run = 0;
	time		t0;
	sync_control_command_generator u_sync_control_command_generator (.core_clk, .sys_rst,
		.hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
		.hreadyout, .hresp, .orbit_ext, .slot_busy, .fe_ready, .l1_empty, .cmd_out,
		.bunch_clear_int, .event_id_clear_int, .l0_throttle, .l1_throttle, .l1_tx_stop,
		.flush_req);
	bcast_partner u_bcast_partner (.core_clk, .sys_rst, .busy, .cmd_out, .flush_req,
		.slot_busy, .fe_ready, .l1_empty);
	// ****
	// bus and compare tasks
	// ****
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one single transfer; waits on hready, never on a fixed count
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		hsel <= 1'b1; htrans <= HTRANS_NONSEQ; haddr <= {24'h0, a}; hwrite <= w;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0; hwdata <= d;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d); xfer(1'b1, a, d); endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	// command valid stands one cycle, so it is looked at mid-cycle
	task automatic wait_cmd(input logic [7:0] c);
		int i;
		@(negedge core_clk);
		for (i = 0; i < 400 && !(cmd_out.valid === 1'b1 && cmd_out.code === c); i++)
			@(negedge core_clk);
		chk({23'h0, cmd_out.valid, cmd_out.code}, {23'h0, 1'b1, c});
	endtask
	task automatic stop_test;
		$display("checks %0d failures %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// ****
	// clock, watchdog, tests
	// ****
	initial forever #5 core_clk = ~core_clk;
	initial begin
		repeat (20000) @(posedge core_clk);
		n_fail++;
		stop_test;
	end
	initial begin
		repeat (5) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(CFG_BASE + 8'h18, 32'h240);
		rd(8'h30, 32'h0);
		wr(CFG_BASE + 8'h04, 32'h5);
		wr(CFG_BASE + 8'h08, 32'h3);
		wr(CFG_BASE, 32'h63);
		wait_cmd(BIT_BUNCH);
		t0 = $time;
		wait_cmd(BIT_BUNCH);
		chk(32'(($time - t0) / 10), 32'h63);
		repeat (97) @(negedge core_clk);
		chk({31'h0, bunch_clear_int & event_id_clear_int}, 32'h1);
		wr(REQ_OFS, 32'h1);
		wait_cmd(BIT_BUNCH | BIT_EVENT);
		rd(REQ_OFS, 32'h0);
		rd(CNT_BASE + 8'h04, 32'h1);
		wr(CFG_BASE + 8'h14, 32'h14);
		wr(CFG_BASE + 8'h18, 32'hA);
		wr(CFG_BASE + 8'h1C, 32'h5);
		wr(REQ_OFS, 32'h2);
		wait_cmd(RESET_CLASS | BIT_FE);
		chk({31'h0, l0_throttle}, 32'h1);
		rd(CNT_BASE + 8'h08, 32'h1);
		wr(CFG_BASE + 8'h24, 32'h28);
		wr(CFG_BASE + 8'h28, 32'hA);
		wr(CFG_BASE + 8'h2C, 32'h5);
		repeat (40) @(posedge core_clk);
		chk({31'h0, l0_throttle}, 32'h0);
		wr(REQ_OFS, 32'h4);
		wait_cmd(RESET_CLASS | BIT_COMB | BIT_FE);
		chk({30'h0, l1_throttle, l0_throttle}, 32'h3);
		rd(CNT_BASE + 8'h0C, 32'h1);
		// the arbiter refuses the user slot for a whole orbit
		busy <= 1'b1;
		wr(CFG_BASE + 8'h30, 32'h30);
		wr(CFG_BASE + 8'h34, 32'h1E);
		wr(REQ_OFS, 32'h8);
		repeat (120) @(posedge core_clk);
		rd(STAT_OFS, 32'h4);
		busy <= 1'b0;
		wait_cmd(8'h30);
		rd(CNT_BASE + 8'h10, 32'h1);
		wr(CTRL_OFS, 32'h12);
		wait_cmd(BIT_BUNCH | BIT_EVENT);
		wait_cmd(8'h30);
		wait_cmd(8'h30);
		wr(CTRL_OFS, 32'h1);
		orbit_ext <= 1'b1;
		t0 = $time;
		@(posedge core_clk) orbit_ext <= 1'b0;
		wait_cmd(BIT_BUNCH);
		chk(32'(($time - t0) / 10), 32'h7);
		stop_test;
	end
endmodule // tb
bind sync_control_command_generator cmd_gen_checker u_cmd_gen_checker (.core_clk, .sys_rst,
	.cmd_out, .bunch_clear_int, .event_id_clear_int, .l0_throttle, .l1_throttle,
	.l1_tx_stop, .flush_req, .fe_ready, .l1_empty);
`default_nettype wire
